// ### core/msdc_consts.svh
// Purpose: Offsets, field positions, reset values for the spacing/deviation bank
// Assumes: Register byte address is four times the index
// Notes: Definitions only
`ifndef MSDC_CONSTS_SVH
`define MSDC_CONSTS_SVH
`define MSDC_IDX_EXP 16'hdf0f
`define MSDC_IDX_MANT 16'hdf10
`define MSDC_IDX_DEV 16'hdf11
`define MSDC_IDX_MODE 16'hdf20
`define MSDC_EXP_RST 2'h2
`define MSDC_MANT_RST 8'hf8
`define MSDC_DEV_E_RST 3'h4
`define MSDC_DEV_M_RST 3'h7
`define MSDC_DEV_E_LSB 4
`define MSDC_DEV_E_MSB 6
`define MSDC_DEV_M_LSB 0
`define MSDC_DEV_M_MSB 2
`define MSDC_MODE_MSK_BIT 0
`define MSDC_MODE_TX_BIT 1
`define MSDC_SPACING_BASE 12'h100
`define MSDC_DEV_BASE 11'h008
`endif

// ### core/msdc_pkg.sv
// Purpose: Types shared by the spacing/deviation bank
// Assumes: Nothing beyond the constants header
// Notes: Register selector used by the bus decode
package msdc_pkg;
    typedef enum logic [2:0] {
        MSDC_SEL_NONE,
        MSDC_SEL_EXP,
        MSDC_SEL_MANT,
        MSDC_SEL_DEV,
        MSDC_SEL_MODE
    } msdc_sel_e;
    typedef logic [25:0] msdc_freq_t;
endpackage : msdc_pkg

// ### core/msdc_calc.sv
// Purpose: Spacing, deviation and channel frequency arithmetic
// Assumes: Inputs come from flip-flops on the same clock
// Notes: Frequencies in units of fref/2^18, deviation in fref/2^17
`include "msdc_consts.svh"
module msdc_calc
    import msdc_pkg::*;
(
    input wire logic [7:0] spacing_mantissa,
    input wire logic [1:0] spacing_exponent,
    input wire logic [2:0] dev_mantissa,
    input wire logic [2:0] dev_exponent,
    input wire logic [23:0] base_freq,
    input wire logic [7:0] channel_number,
    output logic [11:0] spacing_step,
    output logic [10:0] dev_step,
    output msdc_freq_t channel_number_freq
);
    logic [19:0] offset;

    always_comb begin
        // Implied leading one above the mantissa
        spacing_step = (`MSDC_SPACING_BASE + {4'h0, spacing_mantissa}) << spacing_exponent; // [RL1] [RL2]
        dev_step = (`MSDC_DEV_BASE + {8'h00, dev_mantissa}) << dev_exponent; // [RL4]
        offset = {8'h00, spacing_step} * {12'h000, channel_number};
        channel_number_freq = {base_freq, 2'b00} + {6'h00, offset}; // [RL3]
    end
endmodule : msdc_calc

// ### core/msdc_top.sv
// Purpose: Channel spacing and deviation configuration bank on AHB-Lite
// Assumes: Zero wait state slave, single word transfers, response always OKAY
// Notes: Base frequency, channel number and symbol come from same-clock logic
// Summary of operation
// [RL1] Eight-bit spacing mantissa, reset 0xf8, with an implied leading one.
// [RL2] Spacing is fref/2^18 times (256 + mantissa) times 2^exponent, unsigned.
// [RL3] Operating frequency is base frequency plus spacing times channel number.
// [RL4] FSK deviation is fref/2^17 times (8 + mantissa) times 2^exponent.
// [RL5] FSK transmit shifts down by deviation for zero, up for one.
// [RL6] MSK transmit: setting picks phase-change fraction 1/8..8/8, +90 zero, -90 one.
// [RL7] FSK receive uses the setting as expected deviation; software programs it closely.
// [RL8] MSK receive ignores the deviation register entirely.
// [RL9] Two-bit spacing exponent in a separate register, reset binary 10.
// [RL10] Deviation bits 7 and 3 read zero and ignore writes.
`include "msdc_consts.svh"
module msdc_top
    import msdc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [23:0] base_freq,
    input wire logic [7:0] channel_number,
    input wire logic tx_symbol,
    output msdc_freq_t channel_number_freq,
    output msdc_freq_t tx_freq,
    output logic [10:0] rx_expected_dev,
    output logic rx_dev_valid,
    output logic [3:0] msk_phase_eighths,
    output logic msk_phase_neg
);
    // Bus phase state
    msdc_sel_e wsel_q, wsel_d;
    logic [31:0] hrdata_q, hrdata_d;
    // Register state
    logic [1:0] exp_q, exp_d;
    logic [7:0] mant_q, mant_d;
    logic [2:0] dev_e_q, dev_e_d;
    logic [2:0] dev_m_q, dev_m_d;
    logic msk_q, msk_d;
    logic tx_q, tx_d;
    // Output state
    msdc_freq_t channel_number_freq_q, channel_number_freq_d;
    msdc_freq_t tx_freq_q, tx_freq_d;
    logic [10:0] rx_dev_q, rx_dev_d;
    logic rx_valid_q, rx_valid_d;
    logic [3:0] msk_frac_q, msk_frac_d;
    logic msk_neg_q, msk_neg_d;

    logic [11:0] spacing_step;
    logic [10:0] dev_step;
    msdc_freq_t calc_freq;
    msdc_sel_e asel;
    logic addr_phase;

    function automatic msdc_sel_e decode(input logic [31:0] addr);
        msdc_sel_e s;
        s = MSDC_SEL_NONE;
        if (addr[1:0] == 2'b00 && addr[31:18] == 14'h0000) begin
            unique case (addr[17:2])
                `MSDC_IDX_EXP: s = MSDC_SEL_EXP;
                `MSDC_IDX_MANT: s = MSDC_SEL_MANT;
                `MSDC_IDX_DEV: s = MSDC_SEL_DEV;
                `MSDC_IDX_MODE: s = MSDC_SEL_MODE;
                default: s = MSDC_SEL_NONE;
            endcase
        end
        return s;
    endfunction : decode

    msdc_calc i_msdc_calc (
        .spacing_mantissa(mant_q),
        .spacing_exponent(exp_q),
        .dev_mantissa(dev_m_q),
        .dev_exponent(dev_e_q),
        .base_freq(base_freq),
        .channel_number(channel_number),
        .spacing_step(spacing_step),
        .dev_step(dev_step),
        .channel_number_freq(calc_freq)
    );

    assign addr_phase = hsel && hready && htrans[1];
    assign asel = decode(haddr);

    // Bus: read data is captured in the address phase so it stands from flip-flops
    always_comb begin
        wsel_d = MSDC_SEL_NONE;
        hrdata_d = hrdata_q;
        if (addr_phase) begin
            if (hwrite) begin
                wsel_d = asel;
            end else begin
                unique case (asel)
                    MSDC_SEL_EXP: hrdata_d = {30'h0, exp_q}; // [RL9]
                    MSDC_SEL_MANT: hrdata_d = {24'h0, mant_q};
                    MSDC_SEL_DEV: hrdata_d = {25'h0, dev_e_q, 1'b0, dev_m_q}; // [RL10]
                    MSDC_SEL_MODE: hrdata_d = {30'h0, tx_q, msk_q};
                    MSDC_SEL_NONE: hrdata_d = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wsel_q <= MSDC_SEL_NONE;
            hrdata_q <= 32'h0000_0000;
        end else begin
            wsel_q <= wsel_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Registers: writes land in the data phase
    always_comb begin
        exp_d = exp_q;
        mant_d = mant_q;
        dev_e_d = dev_e_q;
        dev_m_d = dev_m_q;
        msk_d = msk_q;
        tx_d = tx_q;
        unique case (wsel_q)
            MSDC_SEL_EXP: exp_d = hwdata[1:0]; // [RL9]
            MSDC_SEL_MANT: mant_d = hwdata[7:0]; // [RL1]
            MSDC_SEL_DEV: begin
                // Bits 7 and 3 have no storage
                dev_e_d = hwdata[`MSDC_DEV_E_MSB:`MSDC_DEV_E_LSB]; // [RL10]
                dev_m_d = hwdata[`MSDC_DEV_M_MSB:`MSDC_DEV_M_LSB];
            end
            MSDC_SEL_MODE: begin
                msk_d = hwdata[`MSDC_MODE_MSK_BIT];
                tx_d = hwdata[`MSDC_MODE_TX_BIT];
            end
            MSDC_SEL_NONE: begin
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            exp_q <= `MSDC_EXP_RST; // [RL9]
            mant_q <= `MSDC_MANT_RST; // [RL1]
            dev_e_q <= `MSDC_DEV_E_RST;
            dev_m_q <= `MSDC_DEV_M_RST;
            msk_q <= 1'b0;
            tx_q <= 1'b0;
        end else begin
            exp_q <= exp_d;
            mant_q <= mant_d;
            dev_e_q <= dev_e_d;
            dev_m_q <= dev_m_d;
            msk_q <= msk_d;
            tx_q <= tx_d;
        end
    end

    // Modulation outputs, one cycle behind their inputs
    always_comb begin
        channel_number_freq_d = calc_freq; // [RL3]
        tx_freq_d = calc_freq;
        rx_dev_d = 11'h000;
        rx_valid_d = 1'b0;
        msk_frac_d = 4'h0;
        msk_neg_d = 1'b0;
        if (tx_q) begin
            if (msk_q) begin
                // Mantissa 0..7 maps to 1/8..8/8 of a symbol
                msk_frac_d = {1'b0, dev_m_q} + 4'h1; // [RL6]
                msk_neg_d = tx_symbol; // [RL6]
            end else if (tx_symbol) begin
                // Deviation is in twice the units of the frequency word
                tx_freq_d = calc_freq + {14'h0, dev_step, 1'b0}; // [RL5]
            end else begin
                tx_freq_d = calc_freq - {14'h0, dev_step, 1'b0}; // [RL5]
            end
        end else if (!msk_q) begin // [RL8]
            rx_dev_d = dev_step; // [RL7]
            rx_valid_d = 1'b1;
        end
        // MSK receive falls through, so no deviation term reaches any output
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            channel_number_freq_q <= 26'h0;
            tx_freq_q <= 26'h0;
            rx_dev_q <= 11'h000;
            rx_valid_q <= 1'b0;
            msk_frac_q <= 4'h0;
            msk_neg_q <= 1'b0;
        end else begin
            channel_number_freq_q <= channel_number_freq_d;
            tx_freq_q <= tx_freq_d;
            rx_dev_q <= rx_dev_d;
            rx_valid_q <= rx_valid_d;
            msk_frac_q <= msk_frac_d;
            msk_neg_q <= msk_neg_d;
        end
    end

    assign channel_number_freq = channel_number_freq_q;
    assign tx_freq = tx_freq_q;
    assign rx_expected_dev = rx_dev_q;
    assign rx_dev_valid = rx_valid_q;
    assign msk_phase_eighths = msk_frac_q;
    assign msk_phase_neg = msk_neg_q;
endmodule : msdc_top

// ### bench/msdc_top_sva.sv
// Purpose: Port-level checks for the spacing/deviation bank
// Assumes: One clock, asynchronous active-low reset
// Notes: Register contents are not visible here, so checks tie outputs together
module msdc_top_sva
    import msdc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [23:0] base_freq,
    input wire logic [7:0] channel_number,
    input wire logic tx_symbol,
    input wire msdc_freq_t channel_number_freq,
    input wire msdc_freq_t tx_freq,
    input wire logic [10:0] rx_expected_dev,
    input wire logic rx_dev_valid,
    input wire logic [3:0] msk_phase_eighths,
    input wire logic msk_phase_neg
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    chk_bus_okay:
        assert property (hreadyout && !hresp) else $error("bus stall or error");
    chk_channel_number_base:
        assert property (hresetn && channel_number == 8'h0 |=>
            channel_number_freq == {$past(base_freq), 2'h0}) else $error("channel_number freq not base");
    chk_rx_dev_zero:
        assert property (!rx_dev_valid |-> rx_expected_dev == 11'h0) else $error("rx dev leak");
    chk_rx_dev_min:
        assert property (rx_dev_valid |-> rx_expected_dev >= 11'h8) else $error("rx dev low");
    chk_msk_range:
        assert property (msk_phase_eighths <= 4'h8 && !(msk_phase_eighths != 4'h0 && rx_dev_valid))
            else $error("msk fraction bad");
    chk_msk_sign:
        assert property (msk_phase_eighths != 4'h0 && $stable(tx_symbol) |->
            msk_phase_neg == tx_symbol) else $error("msk sign wrong");
    chk_msk_idle:
        assert property (msk_phase_eighths == 4'h0 |-> !msk_phase_neg) else $error("msk sign idle");
    chk_rx_no_shift:
        assert property (rx_dev_valid && $stable(channel_number_freq) |-> tx_freq == channel_number_freq)
            else $error("rx shifts carrier");
    chk_fsk_dir:
        assert property (tx_freq != channel_number_freq && $stable(channel_number_freq) && $stable(tx_symbol) |->
            (tx_freq > channel_number_freq) == tx_symbol) else $error("fsk direction");
    cover property (rx_dev_valid);
    cover property (msk_phase_eighths == 4'h8);
    cover property (tx_freq > channel_number_freq);
endmodule : msdc_top_sva

// ### bench/modem_spacing_deviation_cfg_bench.sv
// Purpose: Self-checking bench for the spacing/deviation bank
// Assumes: Zero wait state slave, byte address four times the index
// Notes: Expected values are recomputed here from the formulas
`include "msdc_consts.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin n_errors++; \
    $display("mismatch %s exp %0h got %0h", n, e, s); end end
module modem_spacing_deviation_cfg_bench
    import msdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tx_symbol = 0;
    logic [31:0] haddr = 0, hwdata = 0, rd;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h0;
    logic [23:0] base_freq = 24'h123456;
    logic [7:0] channel_number = 0;
    logic hreadyout, hresp, rx_dev_valid, msk_phase_neg;
    logic [31:0] hrdata;
    msdc_freq_t channel_number_freq, tx_freq, ec;
    logic [10:0] rx_expected_dev;
    logic [3:0] msk_phase_eighths;
    int n_errors = 0, num_checks = 0;
    msdc_top i_msdc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .base_freq(base_freq),
        .channel_number(channel_number), .tx_symbol(tx_symbol), .channel_number_freq(channel_number_freq),
        .tx_freq(tx_freq), .rx_expected_dev(rx_expected_dev), .rx_dev_valid(rx_dev_valid),
        .msk_phase_eighths(msk_phase_eighths), .msk_phase_neg(msk_phase_neg));
    initial begin
        forever #50 hclk = ~hclk;
    end
    task automatic bus(input logic w, input logic [15:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= {14'h0, idx, 2'h0};
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (!hreadyout) @(posedge hclk);
        rd = hrdata;
    endtask : bus
    task automatic rchk(input logic [15:0] idx, input logic [31:0] ex);
        bus(1'b0, idx, 32'h0);
        `CHK("reg", ex, rd)
    endtask : rchk
    // Outputs lag one edge; three edges cover a write's own latency too
    task automatic settle();
        repeat (3) @(posedge hclk);
        #1;
    endtask : settle
    task automatic t_regs();
        rchk(`MSDC_IDX_MANT, 32'hf8);
        rchk(`MSDC_IDX_EXP, 32'h2);
        rchk(`MSDC_IDX_DEV, 32'h47);
        bus(1'b1, `MSDC_IDX_DEV, 32'hffffffff);
        rchk(`MSDC_IDX_DEV, 32'h77);
        bus(1'b1, `MSDC_IDX_EXP, 32'hff);
        rchk(`MSDC_IDX_EXP, 32'h3);
        // Unmapped place: write dropped, reads zero
        bus(1'b1, 16'hdf12, 32'h5a);
        rchk(16'hdf12, 32'h0);
    endtask : t_regs
    task automatic t_channel_number();
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, `MSDC_IDX_EXP, 32'(e));
            bus(1'b1, `MSDC_IDX_MANT, 32'(e * 85));
            channel_number <= 8'(255 - e * 60);
            settle();
            ec = {base_freq, 2'h0} + ((256 + e * 85) << e) * (255 - e * 60);
            `CHK("channel_number", ec, channel_number_freq)
        end
    endtask : t_channel_number
    task automatic t_dev();
        logic [2:0] m, e;
        int d;
        for (int i = 0; i < 8; i++) begin
            m = 3'(7 - i);
            e = 3'(i);
            d = (8 + m) << e;
            bus(1'b1, `MSDC_IDX_DEV, {24'h0, 1'b1, e, 1'b1, m});
            for (int md = 0; md < 4; md++) begin
                bus(1'b1, `MSDC_IDX_MODE, 32'(md));
                for (int s = 0; s < 2; s++) begin
                    // Symbol changes only on a rising edge
                    @(posedge hclk);
                    tx_symbol <= s[0];
                    settle();
                    `CHK("valid", md == 0, rx_dev_valid)
                    case (md)
                        0: `CHK("rxdev", 11'(d), rx_expected_dev)
                        1: `CHK("rxmsk", ec, tx_freq)
                        2: `CHK("txfsk", msdc_freq_t'(s ? ec + 2 * d : ec - 2 * d), tx_freq)
                        default: `CHK("msk", {s[0], 4'(m + 1)}, {msk_phase_neg, msk_phase_eighths})
                    endcase
                end
            end
        end
    endtask : t_dev
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_channel_number();
        t_dev();
        report_and_stop();
    end
    initial begin
        #1000000;
        n_errors++;
        report_and_stop();
    end
endmodule : modem_spacing_deviation_cfg_bench
bind msdc_top msdc_top_sva i_msdc_top_sva (.hclk(hclk), .hresetn(hresetn),
    .hreadyout(hreadyout), .hresp(hresp), .base_freq(base_freq),
    .channel_number(channel_number), .tx_symbol(tx_symbol), .channel_number_freq(channel_number_freq),
    .tx_freq(tx_freq), .rx_expected_dev(rx_expected_dev), .rx_dev_valid(rx_dev_valid),
    .msk_phase_eighths(msk_phase_eighths), .msk_phase_neg(msk_phase_neg));
